// [verilog/cid_decoder.sv]
// cid_decoder: expands compressed 16-bit halfwords into full 32-bit instructions
// assumes fetch presents one halfword with a valid strobe; execute takes the registered result
module cid_decoder (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // fetch side
  input  wire logic        half_valid,
  input  wire logic [15:0] half_in,
  // execute side
  output logic             word_valid,
  output logic [31:0]      word_out,
  output logic             sets_flags,
  output logic             branch_with_return,
  output logic             branch_state_switch,
  output logic             unsupported
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // data-processing word: cond 00 I op S rn rd operand2
  function automatic logic [31:0] dp(input logic imm, input logic [3:0] op, input logic s,
                                     input logic [3:0] rn, input logic [3:0] rd,
                                     input logic [11:0] op2);
    dp = {cid_pkg::COND_AL, 2'h0, imm, op, s, rn, rd, op2};
  endfunction

  function automatic logic [3:0] lo(input logic [2:0] r);
    lo = {1'b0, r};
  endfunction

  // register-shift type of the register-pair group; rotate takes the default
  // only reached for the four shift opcodes, so the default never hides a bad code
  function automatic logic [1:0] alu_shift_code(input logic [3:0] op);
    case (op)
      4'h2:    alu_shift_code = 2'h0;
      4'h3:    alu_shift_code = 2'h1;
      4'h4:    alu_shift_code = 2'h2;
      default: alu_shift_code = 2'h3;
    endcase
  endfunction

  // ------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------
  // every operand field but the immediate-move register (half_in[10:8]) is sliced; the format class says which ones count
  cid_fields_if fl ();
  cid_fields u_fields (
    .half (half_in),
    .f    (fl)
  );

  // ------------------------------------------------------------
  // expansion
  // ------------------------------------------------------------
  logic [31:0] next_word_out;
  logic        next_word_valid;
  logic        next_sets_flags;
  logic        next_branch_with_return;
  logic        next_branch_state_switch;
  logic        next_unsupported;

  always_comb begin
    next_word_valid          = half_valid;
    next_word_out            = cid_pkg::NOP_WORD;
    next_sets_flags          = 1'b0;
    next_branch_with_return  = 1'b0;
    next_branch_state_switch = 1'b0;
    next_unsupported         = 1'b0;
    case (fl.fmt)
      cid_pkg::FMT_SHIFT: begin
        // shift type 00/01/10 maps straight onto the operand2 shift code
        next_word_out   = dp(1'b0, cid_pkg::DP_MOV, 1'b1, 4'h0, lo(fl.dst_index),
                             {fl.imm_five_field, half_in[12:11], 1'b0, lo(fl.src_index)});
        next_sets_flags = 1'b1;
      end
      cid_pkg::FMT_ADDSUB: begin
        next_word_out   = dp(half_in[10], half_in[9] ? cid_pkg::DP_SUB : cid_pkg::DP_ADD, 1'b1,
                             lo(fl.src_index), lo(fl.dst_index),
                             half_in[10] ? {9'h000, fl.imm_three_field}
                                         : {8'h00, lo(fl.offset_index)});
        next_sets_flags = 1'b1;
      end
      cid_pkg::FMT_MOVIMM: begin
        case (half_in[12:11])
          2'h0: next_word_out = dp(1'b1, cid_pkg::DP_MOV, 1'b1, 4'h0, lo(half_in[10:8]),
                                   {4'h0, fl.imm_eight_field});
          2'h1: next_word_out = dp(1'b1, cid_pkg::DP_CMP, 1'b1, lo(half_in[10:8]), 4'h0,
                                   {4'h0, fl.imm_eight_field});
          2'h2: next_word_out = dp(1'b1, cid_pkg::DP_ADD, 1'b1, lo(half_in[10:8]), lo(half_in[10:8]),
                                   {4'h0, fl.imm_eight_field});
          default: next_word_out = dp(1'b1, cid_pkg::DP_SUB, 1'b1, lo(half_in[10:8]), lo(half_in[10:8]),
                                      {4'h0, fl.imm_eight_field});
        endcase
        next_sets_flags = 1'b1;
      end
      cid_pkg::FMT_ALU: begin
        next_sets_flags = 1'b1;
        case (half_in[9:6])
          4'h0: next_word_out = dp(1'b0, cid_pkg::DP_AND, 1'b1, lo(fl.dst_index), lo(fl.dst_index),
                                   {8'h00, lo(fl.src_index)});
          4'h1: next_word_out = dp(1'b0, cid_pkg::DP_EOR, 1'b1, lo(fl.dst_index), lo(fl.dst_index),
                                   {8'h00, lo(fl.src_index)});
          4'h2, 4'h3, 4'h4, 4'h7: begin
            // register-specified shift: shift register in [11:8], type in [6:5], bit4 set
            next_word_out = dp(1'b0, cid_pkg::DP_MOV, 1'b1, 4'h0, lo(fl.dst_index),
                               {lo(fl.src_index), 1'b0, alu_shift_code(half_in[9:6]), 1'b1, lo(fl.dst_index)});
          end
          4'h5: next_word_out = dp(1'b0, cid_pkg::DP_ADC, 1'b1, lo(fl.dst_index), lo(fl.dst_index),
                                   {8'h00, lo(fl.src_index)});
          4'h6: next_word_out = dp(1'b0, cid_pkg::DP_SBC, 1'b1, lo(fl.dst_index), lo(fl.dst_index),
                                   {8'h00, lo(fl.src_index)});
          4'h8: next_word_out = dp(1'b0, cid_pkg::DP_TST, 1'b1, lo(fl.dst_index), 4'h0,
                                   {8'h00, lo(fl.src_index)});
          4'h9: next_word_out = dp(1'b1, cid_pkg::DP_RSB, 1'b1, lo(fl.src_index), lo(fl.dst_index),
                                   12'h000);
          4'ha: next_word_out = dp(1'b0, cid_pkg::DP_CMP, 1'b1, lo(fl.dst_index), 4'h0,
                                   {8'h00, lo(fl.src_index)});
          4'hb: next_word_out = dp(1'b0, cid_pkg::DP_CMN, 1'b1, lo(fl.dst_index), 4'h0,
                                   {8'h00, lo(fl.src_index)});
          4'hc: next_word_out = dp(1'b0, cid_pkg::DP_ORR, 1'b1, lo(fl.dst_index), lo(fl.dst_index),
                                   {8'h00, lo(fl.src_index)});
          4'hd: next_word_out = cid_pkg::MUL_BASE | {12'h000, lo(fl.dst_index), 4'h0,
                                                     lo(fl.dst_index), 4'h0, lo(fl.src_index)};
          4'he: next_word_out = dp(1'b0, cid_pkg::DP_BIC, 1'b1, lo(fl.dst_index), lo(fl.dst_index),
                                   {8'h00, lo(fl.src_index)});
          default: next_word_out = dp(1'b0, cid_pkg::DP_MVN, 1'b1, 4'h0, lo(fl.dst_index),
                                      {8'h00, lo(fl.src_index)});
        endcase
      end
      cid_pkg::FMT_HIREG: begin
        // only compare sets flags here; add and move leave them alone
        case (half_in[9:8])
          2'h0: next_word_out = dp(1'b0, cid_pkg::DP_ADD, 1'b0, fl.high_dst_index, fl.high_dst_index,
                                   {8'h00, fl.high_src_index});
          2'h1: begin
            next_word_out   = dp(1'b0, cid_pkg::DP_CMP, 1'b1, fl.high_dst_index, 4'h0,
                                 {8'h00, fl.high_src_index});
            next_sets_flags = 1'b1;
          end
          2'h2: next_word_out = dp(1'b0, cid_pkg::DP_MOV, 1'b0, 4'h0, fl.high_dst_index,
                                   {8'h00, fl.high_src_index});
          default: begin
            next_word_out            = cid_pkg::SWITCH_BASE | {28'h0000000, fl.high_src_index};
            next_branch_state_switch = 1'b1;
          end
        endcase
      end
      cid_pkg::FMT_REGLS: begin
        // single data transfer, register offset, pre-index, up
        next_word_out = {cid_pkg::COND_AL, 2'h1, 1'b1, 1'b1, 1'b1, half_in[10], 1'b0, half_in[11],
                         lo(fl.base_index), lo(fl.dst_index), 8'h00, lo(fl.offset_index)};
      end
      cid_pkg::FMT_IMMLS: begin
        // word offsets are scaled by four, byte offsets are not
        next_word_out = {cid_pkg::COND_AL, 2'h1, 1'b0, 1'b1, 1'b1, half_in[12], 1'b0, half_in[11],
                         lo(fl.base_index), lo(fl.dst_index),
                         half_in[12] ? {7'h00, fl.imm_five_field} : {5'h00, fl.imm_five_field, 2'h0}};
      end
      cid_pkg::FMT_SPADJ: begin
        // magnitude is in words; its top bit lands in the rotate field, so only up to 252 bytes encode unrotated
        next_word_out = dp(1'b1, half_in[7] ? cid_pkg::DP_SUB : cid_pkg::DP_ADD, 1'b0,
                           cid_pkg::SP_REG, cid_pkg::SP_REG,
                           {3'h0, fl.stack_adjust_mag, 2'h0});
        next_sets_flags = 1'b0;
      end
      cid_pkg::FMT_LBRL: begin
        // the pair needs the core's lr accumulation; only the half is passed on
        next_branch_with_return = 1'b1;
        next_word_out = half_in[11]
          ? {cid_pkg::COND_AL, 8'h00, 4'h0, 5'h00, fl.long_offset} | 32'h0b000000
          : {cid_pkg::COND_AL, 8'h28, 4'h0, 5'h00, fl.long_offset} | 32'h00000000;
      end
      default: begin
        // left to the core's full decoder; no expansion is attempted here
        next_unsupported = half_valid;
      end
    endcase
    // idle cycles still move word_out, but must never raise a side flag
    if (!half_valid) begin
      next_sets_flags          = 1'b0;
      next_branch_with_return  = 1'b0;
      next_branch_state_switch = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // output register
  // ------------------------------------------------------------
  // word_out loads every cycle, valid or not: no enable on 32 flops,
  // so execute must qualify it with word_valid
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      word_valid          <= 1'b0;
      word_out            <= cid_pkg::NOP_WORD;
      sets_flags          <= 1'b0;
      branch_with_return  <= 1'b0;
      branch_state_switch <= 1'b0;
      unsupported         <= 1'b0;
    end else begin
      word_valid          <= next_word_valid;
      word_out            <= next_word_out;
      sets_flags          <= next_sets_flags;
      branch_with_return  <= next_branch_with_return;
      branch_state_switch <= next_branch_state_switch;
      unsupported         <= next_unsupported;
    end
  end
endmodule

// [verilog/cid_pkg.sv]
// cid_pkg: constants for the compressed instruction decoder
// assumes a single core clock domain; no register map (plain ports)
package cid_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  // ----------------------------------------
  // format match patterns
  // ----------------------------------------
  localparam logic [5:0] HIREG_PAT  = 6'h11; // 010001
  localparam logic [3:0] REGLS_PAT  = 4'h5;  // 0101, bit 9 clear
  localparam logic [2:0] IMMLS_PAT  = 3'h3;  // 011
  localparam logic [7:0] SPADJ_PAT  = 8'hb0; // 10110000
  localparam logic [3:0] LBRL_PAT   = 4'hf;  // 1111
  localparam logic [2:0] SHIFT_PAT  = 3'h0;  // 000, op != 11
  localparam logic [4:0] ADDSUB_PAT = 5'h03; // 00011
  localparam logic [2:0] MOVIMM_PAT = 3'h1;  // 001
  localparam logic [5:0] ALU_PAT    = 6'h10; // 010000
  // ----------------------------------------
  // expanded data-processing opcodes
  // ----------------------------------------
  localparam logic [3:0] DP_AND = 4'h0;
  localparam logic [3:0] DP_EOR = 4'h1;
  localparam logic [3:0] DP_SUB = 4'h2;
  localparam logic [3:0] DP_RSB = 4'h3;
  localparam logic [3:0] DP_ADD = 4'h4;
  localparam logic [3:0] DP_ADC = 4'h5;
  localparam logic [3:0] DP_SBC = 4'h6;
  localparam logic [3:0] DP_TST = 4'h8;
  localparam logic [3:0] DP_CMP = 4'ha;
  localparam logic [3:0] DP_CMN = 4'hb;
  localparam logic [3:0] DP_ORR = 4'hc;
  localparam logic [3:0] DP_MOV = 4'hd;
  localparam logic [3:0] DP_BIC = 4'he;
  localparam logic [3:0] DP_MVN = 4'hf;
  // ----------------------------------------
  // expanded-word fixed parts
  // ----------------------------------------
  localparam logic [3:0] COND_AL = 4'he;
  localparam logic [3:0] SP_REG  = 4'hd;
  localparam logic [3:0] PC_REG  = 4'hf;
  localparam logic [3:0] LR_REG  = 4'he;
  localparam logic [31:0] SWITCH_BASE = 32'he12fff10;
  localparam logic [31:0] MUL_BASE    = 32'he0100090;
  localparam logic [31:0] NOP_WORD    = 32'he1a00000;
  // ----------------------------------------
  // format classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    FMT_SHIFT, FMT_ADDSUB, FMT_MOVIMM, FMT_ALU, FMT_HIREG,
    FMT_REGLS, FMT_IMMLS, FMT_SPADJ, FMT_LBRL, FMT_OTHER
  } cid_fmt_t;
endpackage

// [verilog/cid_fields_if.sv]
// cid_fields_if: operand fields carried from the field extractor to the expander
// assumes both ends on the core clock, purely combinational contents
interface cid_fields_if;
  logic [2:0] dst_index;
  logic [2:0] src_index;
  logic [2:0] base_index;
  logic [2:0] offset_index;
  logic [3:0] high_src_index;
  logic [3:0] high_dst_index;
  logic       high_dest_flag;
  logic       high_source_flag;
  logic [4:0] imm_five_field;
  logic [2:0] imm_three_field;
  logic [6:0] stack_adjust_mag;
  logic [7:0] imm_eight_field;
  logic [10:0] long_offset;
  cid_pkg::cid_fmt_t fmt;
  modport src (output dst_index, src_index, base_index, offset_index, high_src_index, high_dst_index,
               high_dest_flag, high_source_flag, imm_five_field, imm_three_field, stack_adjust_mag,
               imm_eight_field, long_offset, fmt);
  modport dst (input dst_index, src_index, base_index, offset_index, high_src_index, high_dst_index,
               high_dest_flag, high_source_flag, imm_five_field, imm_three_field, stack_adjust_mag,
               imm_eight_field, long_offset, fmt);
endinterface

// [verilog/cid_fields.sv]
// cid_fields: classifies a halfword by its leading bits and slices operand fields
// assumes a stable halfword input; combinational only
module cid_fields (
  // instruction halfword
  input  wire logic [15:0] half,
  // extracted fields
  cid_fields_if.src        f
);
  always_comb begin
    f.dst_index        = half[2:0];
    f.src_index        = half[5:3];
    f.base_index       = half[5:3];
    f.offset_index     = half[8:6];
    f.high_dest_flag   = half[7];
    f.high_source_flag = half[6];
    f.high_src_index   = {half[6], half[5:3]};
    f.high_dst_index   = {half[7], half[2:0]};
    f.imm_five_field   = half[10:6];
    f.imm_three_field  = half[8:6];
    f.stack_adjust_mag = half[6:0];
    f.imm_eight_field  = half[7:0];
    f.long_offset      = half[10:0];
    // priority: add/subtract (00011) is tested before the shift pattern (000) that it overlaps
    if (half[15:10] == cid_pkg::HIREG_PAT) begin
      f.fmt = cid_pkg::FMT_HIREG;
    end else if (half[15:10] == cid_pkg::ALU_PAT) begin
      f.fmt = cid_pkg::FMT_ALU;
    end else if (half[15:12] == cid_pkg::REGLS_PAT && !half[9]) begin
      f.fmt = cid_pkg::FMT_REGLS;
    end else if (half[15:13] == cid_pkg::IMMLS_PAT) begin
      f.fmt = cid_pkg::FMT_IMMLS;
    end else if (half[15:8] == cid_pkg::SPADJ_PAT) begin
      f.fmt = cid_pkg::FMT_SPADJ;
    end else if (half[15:12] == cid_pkg::LBRL_PAT) begin
      f.fmt = cid_pkg::FMT_LBRL;
    end else if (half[15:11] == cid_pkg::ADDSUB_PAT) begin
      f.fmt = cid_pkg::FMT_ADDSUB;
    end else if (half[15:13] == cid_pkg::SHIFT_PAT) begin
      f.fmt = cid_pkg::FMT_SHIFT;
    end else if (half[15:13] == cid_pkg::MOVIMM_PAT) begin
      f.fmt = cid_pkg::FMT_MOVIMM;
    end else begin
      f.fmt = cid_pkg::FMT_OTHER;
    end
  end
endmodule

// [verification/cid_decoder_assertions.sv]
// cid_decoder_assertions: port-level checks of the decoder
// assumes only the decoder's top ports; bound at the foot
module cid_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // fetch side
  input wire logic        half_valid,
  input wire logic [15:0] half_in,
  // execute side
  input wire logic        word_valid,
  input wire logic [31:0] word_out,
  input wire logic        sets_flags,
  input wire logic        branch_with_return,
  input wire logic        branch_state_switch,
  input wire logic        unsupported
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic hi;
  assign hi = half_valid && half_in[15:10] == 6'h11;
  sequence s_long;
    half_valid && half_in[15:12] == 4'hf;
  endsequence
  sequence s_long_out;
    branch_with_return && word_out[10:0] == $past(half_in[10:0]);
  endsequence
  a_valid_follows: assert property (half_valid |=> word_valid)
    else $error("word_valid missing one cycle after half_valid");
  a_idle_quiet: assert property (!half_valid |=> !word_valid && !sets_flags && !unsupported)
    else $error("outputs active after an idle cycle");
  // reset must win even though the default disable would hide it
  a_reset_nop: assert property (disable iff (1'b0) !rst_b |=> word_out == cid_pkg::NOP_WORD && !word_valid)
    else $error("reset did not leave a no-op word");
  a_shift_move: assert property (half_valid && half_in[15:13] == 3'h0 && half_in[12:11] != 2'h3
    |=> sets_flags && word_out[24:21] == cid_pkg::DP_MOV && word_out[6:5] == $past(half_in[12:11]))
    else $error("shift expansion wrong");
  a_addsub_op: assert property (half_valid && half_in[15:11] == 5'h03 |=> sets_flags &&
    word_out[24:21] == ($past(half_in[9]) ? cid_pkg::DP_SUB : cid_pkg::DP_ADD))
    else $error("add or subtract expansion wrong");
  a_alu_flags: assert property (half_valid && half_in[15:10] == 6'h10 |=> sets_flags && !unsupported)
    else $error("register-pair operation without flag update");
  a_hireg_quiet: assert property (hi && !half_in[8] |=> !sets_flags)
    else $error("high-register add or move updated flags");
  a_state_switch: assert property (hi && half_in[9:8] == 2'h3 |=> branch_state_switch)
    else $error("branch exchange not flagged");
  a_spadj_sp: assert property (half_valid && half_in[15:8] == 8'hb0 |=> !sets_flags &&
    word_out[15:12] == cid_pkg::SP_REG && word_out[19:16] == cid_pkg::SP_REG)
    else $error("stack adjust expansion wrong");
  a_long_half: assert property (s_long |=> s_long_out)
    else $error("long branch half not carried");
  a_immls_bits: assert property (half_valid && half_in[15:13] == 3'h3 |=> !sets_flags &&
    word_out[20] == $past(half_in[11]) && word_out[22] == $past(half_in[12]))
    else $error("immediate load or store bits wrong");
endmodule

bind cid_decoder cid_chk i_cid_chk (.clock(clock), .rst_b(rst_b), .half_valid(half_valid), .half_in(half_in),
  .word_valid(word_valid), .word_out(word_out), .sets_flags(sets_flags), .branch_with_return(branch_with_return),
  .branch_state_switch(branch_state_switch), .unsupported(unsupported));

// [verification/cid_exec_model.sv]
// cid_exec_model: execute-stage stand-in that takes each expanded word
// assumes registered words qualified by word_valid on the core clock
module cid_exec_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // from the decoder
  input  wire logic        word_valid,
  input  wire logic [31:0] word_out,
  // what execute has taken
  output logic [31:0]      last_word,
  output logic [15:0]      n_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      last_word <= 32'h0000_0000;
      n_taken   <= 16'h0000;
    end else if (word_valid) begin
      last_word <= word_out;
      n_taken   <= n_taken + 16'h0001;
    end
  end
endmodule

// [verification/tb_top.sv]
// tb_top: self-checking bench for the compressed instruction decoder
// assumes the decoder answers one cycle after each halfword
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        half_valid = 1'b0;
  logic [15:0] half_in = 16'h0000;
  logic        word_valid, sets_flags, branch_with_return, branch_state_switch, unsupported;
  logic [31:0] word_out, last_word;
  logic [15:0] n_taken;
  int          fails = 0;
  int          n_compared = 0;
  always #2 clock = ~clock;
  cid_decoder i_cid_decoder (.clock(clock), .rst_b(rst_b), .half_valid(half_valid), .half_in(half_in),
    .word_valid(word_valid), .word_out(word_out), .sets_flags(sets_flags), .branch_with_return(branch_with_return),
    .branch_state_switch(branch_state_switch), .unsupported(unsupported));
  cid_exec_model i_cid_exec_model (.clock(clock), .rst_b(rst_b), .word_valid(word_valid), .word_out(word_out),
    .last_word(last_word), .n_taken(n_taken));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one valid cycle, then outputs are sampled once they have landed
  task automatic issue(input logic [15:0] h);
    @(posedge clock) #1;
    half_valid = 1'b1;
    half_in = h;
    @(posedge clock) #1;
    half_valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_shift();
    for (int op = 0; op < 3; op++) begin
      issue({3'h0, op[1:0], 5'h1b, 3'h5, 3'h2});
      chk("shift flags", 32'(sets_flags), 32'h1);
      chk("shift op", 32'(word_out[24:21]), 32'(cid_pkg::DP_MOV));
      chk("shift kind", 32'(word_out[6:5]), 32'(op));
      chk("shift amount", 32'(word_out[11:7]), 32'h1b);
    end
    $display("test shift done");
  endtask
  task automatic t_addsub();
    logic [3:0] mv_op;
    for (int k = 0; k < 4; k++) begin
      issue({5'h03, k[1], k[0], 3'h6, 3'h2, 3'h6});
      chk("addsub flags", 32'(sets_flags), 32'h1);
      chk("addsub op", 32'(word_out[24:21]), 32'(k[0] ? cid_pkg::DP_SUB : cid_pkg::DP_ADD));
      chk("addsub imm", 32'(word_out[25]), 32'(k[1]));
    end
    for (int k = 0; k < 4; k++) begin
      issue({3'h1, k[1:0], 3'h5, 8'h80});
      mv_op = k[1] ? (k[0] ? cid_pkg::DP_SUB : cid_pkg::DP_ADD) : (k[0] ? cid_pkg::DP_CMP : cid_pkg::DP_MOV);
      chk("movimm flags", 32'(sets_flags), 32'h1);
      chk("movimm op", 32'(word_out[24:21]), 32'(mv_op));
      chk("movimm dst", 32'(word_out[15:12]), 32'(k == 1 ? 0 : 5));
    end
    $display("test addsub done");
  endtask
  task automatic t_alu();
    for (int op = 0; op < 16; op++) begin
      issue({6'h10, op[3:0], 3'h4, 3'h3});
      chk("alu flags", 32'(sets_flags), 32'h1);
      chk("alu known", 32'(unsupported), 32'h0);
      if (op == 7) chk("alu ror", 32'(word_out[11:4]), 32'h47);
      if (op == 13) chk("alu mul", word_out, cid_pkg::MUL_BASE | 32'h0003_0304);
    end
    $display("test alu done");
  endtask
  task automatic t_hireg();
    for (int op = 0; op < 4; op++) begin
      issue({6'h11, op[1:0], 2'h3, 3'h4, 3'h3});
      chk("hi flags", 32'(sets_flags), 32'(op == 1));
      chk("hi switch", 32'(branch_state_switch), 32'(op == 3));
      if (op == 0 || op == 2) chk("hi dst", 32'(word_out[15:12]), 32'hb);
      if (op == 3) chk("hi target", word_out, cid_pkg::SWITCH_BASE | 32'h0000_000c);
    end
    $display("test hireg done");
  endtask
  task automatic t_ldst();
    issue({4'h5, 1'b1, 1'b1, 1'b0, 3'h7, 3'h1, 3'h2});
    chk("reg ls bits", 32'({word_out[22], word_out[20]}), 32'h3);
    chk("reg ls regs", 32'({word_out[19:12], word_out[3:0]}), 32'h127);
    chk("reg ls flags", 32'(sets_flags), 32'h0);
    issue({3'h3, 1'b0, 1'b0, 5'h1f, 3'h3, 3'h4});
    chk("word offset", 32'(word_out[11:0]), 32'h7c);
    chk("word regs", 32'(word_out[19:12]), 32'h34);
    issue({3'h3, 1'b1, 1'b1, 5'h1f, 3'h3, 3'h4});
    chk("byte offset", 32'(word_out[11:0]), 32'h1f);
    chk("byte bits", 32'({word_out[22], word_out[20]}), 32'h3);
    $display("test ldst done");
  endtask
  task automatic t_branch();
    for (int s = 0; s < 2; s++) begin
      issue({8'hb0, s[0], 7'h7f});
      chk("sp flags", 32'(sets_flags), 32'h0);
      chk("sp op", 32'(word_out[24:21]), 32'(s ? cid_pkg::DP_SUB : cid_pkg::DP_ADD));
      issue({4'hf, s[0], 11'h5a5});
      chk("long mark", 32'(branch_with_return), 32'h1);
      chk("long offset", 32'(word_out[10:0]), 32'h5a5);
    end
    issue(16'hdf00);
    chk("unsup flag", 32'(unsupported), 32'h1);
    chk("unsup word", word_out, cid_pkg::NOP_WORD);
    $display("test branch done");
  endtask
  // back to back, then a reset in mid-run with a halfword pending
  task automatic t_stream();
    logic [15:0] n0;
    // the previous test's last word is taken at this edge, so count from after it
    @(posedge clock) #1;
    n0 = n_taken;
    half_valid = 1'b1;
    half_in = 16'h1c0a;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) #1;
      half_in = 16'h4040 + 16'(i);
      if (i > 0) chk("stream valid", 32'(word_valid), 32'h1);
    end
    half_valid = 1'b0;
    @(posedge clock) #1;
    chk("stream count", 32'(n_taken), 32'(n0) + 32'h3);
    chk("stream last", last_word, 32'he031_1000);
    rst_b = 1'b0;
    half_valid = 1'b1;
    @(posedge clock) #1;
    chk("reset word", word_out, cid_pkg::NOP_WORD);
    chk("reset valid", 32'(word_valid), 32'h0);
    rst_b = 1'b1;
    half_valid = 1'b0;
    @(posedge clock) #1;
    chk("idle valid", 32'(word_valid), 32'h0);
    $display("test stream done");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    #1;
    chk("first word", word_out, cid_pkg::NOP_WORD);
    rst_b = 1'b1;
    t_shift();
    t_addsub();
    t_alu();
    t_hireg();
    t_ldst();
    t_branch();
    t_stream();
    tally_and_finish();
  end
  // a hang counts as a mismatch
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule
